// File: design/sla_pkg.sv
// How it works
// - While enabled, clock line owns port B bit 4, data line bit 5.
// - Data register bit 0 sets pin drive; read returns pin level; resets to 1.
// - Clock register bit 0 sets pin drive; read returns pin level; resets to 1.
// - Both lines open-drain; outside pull-low shows in readback.
// - Data falls while clock high: falling condition, flagged only when enabled.
// - Falling flag reads 1 when seen; cleared by any write or reset.
// - Each falling condition raises its interrupt, normally middle request bit 7.
// - Data rises while clock high: rising condition, flagged only when enabled.
// - Rising flag reads 1 when seen; cleared by any write or reset.
// - Each rising condition raises its interrupt, normally middle request bit 6.
// - Condition detectors ignore any transmit or receive direction.
// - Every clock rise captures data level into sampled bit 0; resets 0.
// - Clock rise sets rise flag; reading sampled register clears it; resets 0.
// - Control bit 3 reads 1 while clock held low; sampled write clears.
// - Control bit 1 holds clock low after each falling edge until released.
// - Control bit 2 holds clock low after falling edge if falling flag set.
// - Control bit 0 enables; bits 7 to 4 read 0; all reset 0.
// - Enable puts both port pins into open-drain line mode.
// - Any write to sampled register releases a stretched clock line.
package sla_pkg;

    // Register byte offsets
    localparam logic [7:0] SLA_OFS_DATA_IO = 8'h00;
    localparam logic [7:0] SLA_OFS_CLOCK_IO = 8'h04;
    localparam logic [7:0] SLA_OFS_CONTROL = 8'h08;
    localparam logic [7:0] SLA_OFS_FALL_COND = 8'h0c;
    localparam logic [7:0] SLA_OFS_RISE_COND = 8'h10;
    localparam logic [7:0] SLA_OFS_SAMPLED = 8'h14;
    localparam logic [7:0] SLA_OFS_RISE_SEEN = 8'h18;

    // Field positions
    localparam int SLA_BIT_LINE = 0;
    localparam int SLA_BIT_ENABLE = 0;
    localparam int SLA_BIT_STRETCH_EN = 1;
    localparam int SLA_BIT_COND_STRETCH_EN = 2;
    localparam int SLA_BIT_STRETCH_ACTIVE = 3;

    // Port B pin numbers taken over while enabled
    localparam int SLA_PB_CLOCK_PIN = 4;
    localparam int SLA_PB_DATA_PIN = 5;

    // Default interrupt manager positions
    localparam int SLA_IRQ_FALL_BIT = 7;
    localparam int SLA_IRQ_RISE_BIT = 6;

    // Reset values
    localparam logic SLA_RST_DRIVE = 1'b1;
    localparam logic [2:0] SLA_RST_CTRL = 3'h0;
    localparam logic SLA_RST_FLAG = 1'b0;
    localparam logic [1:0] SLA_RST_SYNC = 2'h3;

    // Writable control fields
    typedef struct packed {
        logic cond_stretch_enable;
        logic stretch_enable;
        logic block_enable;
    } sla_ctrl_t;

    // Filtered line levels
    typedef struct packed {
        logic clock_line;
        logic data_line;
    } sla_lines_t;

endpackage

// File: design/sla_sync_line_assist.sv
// The implementer's own choices: the register offsets and the APB register port.
module sla_sync_line_assist
    import sla_pkg::*;
(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CLOCK_LINE_I,
    output logic CLOCK_LINE_O,
    output logic CLOCK_LINE_OE,
    input wire logic DATA_LINE_I,
    output logic DATA_LINE_O,
    output logic DATA_LINE_OE,
    output logic [5:0] PORT_B_OVERRIDE,
    output logic PORT_B_OPEN_DRAIN,
    output logic FALLING_COND_IRQ,
    output logic RISING_COND_IRQ
);

    logic [2:0] clk_sync_r;
    logic [2:0] dat_sync_r;
    sla_lines_t lines_r;
    sla_lines_t lines_nxt;
    logic clock_rise;
    logic clock_fall;
    logic data_rise;
    logic data_fall;
    logic fall_event;
    logic rise_event;

    logic data_drive_r;
    logic clock_drive_r;
    sla_ctrl_t ctrl_r;
    logic fall_flag_r;
    logic rise_flag_r;
    logic sampled_r;
    logic rise_seen_r;
    logic stretch_r;
    logic fall_irq_r;
    logic rise_irq_r;
    logic [31:0] prdata_r;
    logic slverr_r;

    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic hit;
    logic [31:0] rd_mux;

    // Pin synchronisers, three stages each
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            clk_sync_r <= {SLA_RST_SYNC, 1'b1};
            dat_sync_r <= {SLA_RST_SYNC, 1'b1};
        end
        else
        begin
            clk_sync_r <= {clk_sync_r[1:0], CLOCK_LINE_I};
            dat_sync_r <= {dat_sync_r[1:0], DATA_LINE_I};
        end
    end

    // Accept a new level once stages two and three agree
    always_comb
    begin
        lines_nxt = lines_r;
        if (clk_sync_r[1] == clk_sync_r[2])
        begin
            lines_nxt.clock_line = clk_sync_r[2];
        end
        if (dat_sync_r[1] == dat_sync_r[2])
        begin
            lines_nxt.data_line = dat_sync_r[2];
        end
    end

    // Filtered line levels
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            lines_r <= '1;
        end
        else
        begin
            lines_r <= lines_nxt;
        end
    end

    // Single-cycle edge strobes from the filtered levels
    assign clock_rise = lines_nxt.clock_line & ~lines_r.clock_line;
    assign clock_fall = ~lines_nxt.clock_line & lines_r.clock_line;
    assign data_rise = lines_nxt.data_line & ~lines_r.data_line;
    assign data_fall = ~lines_nxt.data_line & lines_r.data_line;

    // Conditions, regardless of who drives the lines
    assign fall_event = ctrl_r.block_enable & data_fall & lines_r.clock_line;
    assign rise_event = ctrl_r.block_enable & data_rise & lines_r.clock_line;

    // APB phase decode
    assign setup = PSEL & ~PENABLE;
    assign access = PSEL & PENABLE;
    assign wr = access & PWRITE & hit;
    assign rd = access & ~PWRITE & hit;

    // Address decode, aligned words only
    always_comb
    begin
        hit = 1'b1;
        unique case (PADDR)
            SLA_OFS_DATA_IO, SLA_OFS_CLOCK_IO, SLA_OFS_CONTROL,
            SLA_OFS_FALL_COND, SLA_OFS_RISE_COND, SLA_OFS_SAMPLED,
            SLA_OFS_RISE_SEEN: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Read data select; unused bits read zero
    always_comb
    begin
        rd_mux = 32'h0;
        unique case (PADDR)
            SLA_OFS_DATA_IO: rd_mux[SLA_BIT_LINE] = lines_r.data_line;
            SLA_OFS_CLOCK_IO: rd_mux[SLA_BIT_LINE] = lines_r.clock_line;
            SLA_OFS_CONTROL:
            begin
                rd_mux[2:0] = ctrl_r;
                rd_mux[SLA_BIT_STRETCH_ACTIVE] = stretch_r;
            end
            SLA_OFS_FALL_COND: rd_mux[SLA_BIT_LINE] = fall_flag_r;
            SLA_OFS_RISE_COND: rd_mux[SLA_BIT_LINE] = rise_flag_r;
            SLA_OFS_SAMPLED: rd_mux[SLA_BIT_LINE] = sampled_r;
            SLA_OFS_RISE_SEEN: rd_mux[SLA_BIT_LINE] = rise_seen_r;
            default: rd_mux = 32'h0;
        endcase
    end

    // Read data captured in the setup cycle, so it stands through the access
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            prdata_r <= 32'h0;
        end
        else if (setup)
        begin
            prdata_r <= PWRITE ? 32'h0 : rd_mux;
        end
    end

    // Error flag for unmapped addresses, also taken in the setup cycle
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            slverr_r <= 1'b0;
        end
        else if (setup)
        begin
            slverr_r <= ~hit;
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = 1'b1;
    assign PSLVERR = access & slverr_r;

    // Data line drive bit
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            data_drive_r <= SLA_RST_DRIVE;
        end
        else if (wr && PADDR == SLA_OFS_DATA_IO)
        begin
            data_drive_r <= PWDATA[SLA_BIT_LINE];
        end
    end

    // Clock line drive bit
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            clock_drive_r <= SLA_RST_DRIVE;
        end
        else if (wr && PADDR == SLA_OFS_CLOCK_IO)
        begin
            clock_drive_r <= PWDATA[SLA_BIT_LINE];
        end
    end

    // Control register
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ctrl_r <= SLA_RST_CTRL;
        end
        else if (wr && PADDR == SLA_OFS_CONTROL)
        begin
            ctrl_r.block_enable <= PWDATA[SLA_BIT_ENABLE];
            ctrl_r.stretch_enable <= PWDATA[SLA_BIT_STRETCH_EN];
            ctrl_r.cond_stretch_enable <= PWDATA[SLA_BIT_COND_STRETCH_EN];
        end
    end

    // Falling condition flag; a new event beats a clearing write
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            fall_flag_r <= SLA_RST_FLAG;
        end
        else if (fall_event)
        begin
            fall_flag_r <= 1'b1;
        end
        else if (wr && PADDR == SLA_OFS_FALL_COND)
        begin
            fall_flag_r <= 1'b0;
        end
    end

    // Rising condition flag; a new event beats a clearing write
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            rise_flag_r <= SLA_RST_FLAG;
        end
        else if (rise_event)
        begin
            rise_flag_r <= 1'b1;
        end
        else if (wr && PADDR == SLA_OFS_RISE_COND)
        begin
            rise_flag_r <= 1'b0;
        end
    end

    // Falling condition interrupt, one pulse per event
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            fall_irq_r <= 1'b0;
        end
        else
        begin
            fall_irq_r <= fall_event;
        end
    end

    // Rising condition interrupt, one pulse per event
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            rise_irq_r <= 1'b0;
        end
        else
        begin
            rise_irq_r <= rise_event;
        end
    end

    assign FALLING_COND_IRQ = fall_irq_r;
    assign RISING_COND_IRQ = rise_irq_r;

    // Data level captured at each clock rise; value is not meaningful before one
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            sampled_r <= 1'b0;
        end
        else if (clock_rise)
        begin
            sampled_r <= lines_r.data_line;
        end
    end

    // Clock rise flag; a new rise beats a clearing read
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            rise_seen_r <= SLA_RST_FLAG;
        end
        else if (clock_rise)
        begin
            rise_seen_r <= 1'b1;
        end
        else if (rd && PADDR == SLA_OFS_SAMPLED)
        begin
            rise_seen_r <= 1'b0;
        end
    end

    // Clock stretch after a falling clock edge; release by sampled write
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            stretch_r <= 1'b0;
        end
        else if (ctrl_r.block_enable && clock_fall &&
                 (ctrl_r.stretch_enable ||
                  (ctrl_r.cond_stretch_enable && fall_flag_r)))
        begin
            stretch_r <= 1'b1;
        end
        else if (wr && PADDR == SLA_OFS_SAMPLED)
        begin
            stretch_r <= 1'b0;
        end
    end

    // Open-drain pads: only ever pull low, while enabled
    assign DATA_LINE_O = 1'b0;
    assign CLOCK_LINE_O = 1'b0;
    assign DATA_LINE_OE = ctrl_r.block_enable & ~data_drive_r;
    assign CLOCK_LINE_OE = ctrl_r.block_enable & (~clock_drive_r | stretch_r);

    // Port B pin takeover while enabled
    always_comb
    begin
        PORT_B_OVERRIDE = 6'h0;
        PORT_B_OVERRIDE[SLA_PB_CLOCK_PIN] = ctrl_r.block_enable;
        PORT_B_OVERRIDE[SLA_PB_DATA_PIN] = ctrl_r.block_enable;
    end

    assign PORT_B_OPEN_DRAIN = ctrl_r.block_enable;

endmodule

// File: test/sla_assertions.sv
module sla_assertions
    import sla_pkg::*;
(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic CLOCK_LINE_I,
    input wire logic CLOCK_LINE_O,
    input wire logic CLOCK_LINE_OE,
    input wire logic DATA_LINE_I,
    input wire logic DATA_LINE_O,
    input wire logic DATA_LINE_OE,
    input wire logic [5:0] PORT_B_OVERRIDE,
    input wire logic PORT_B_OPEN_DRAIN,
    input wire logic FALLING_COND_IRQ,
    input wire logic RISING_COND_IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    logic dw;
    default clocking @(posedge MCLK);
    endclocking
    default disable iff (!NRST);

    // Write to data drive while enabled
    assign dw = PSEL && PENABLE && PWRITE && PADDR == SLA_OFS_DATA_IO && PORT_B_OPEN_DRAIN;

    // Pins and wires
    AST_OVR: assert property (PORT_B_OVERRIDE == {{2{PORT_B_OPEN_DRAIN}}, 4'h0})
        else $error("override mismatch");
    AST_OD: assert property (!CLOCK_LINE_O && !DATA_LINE_O)
        else $error("line driven high");
    AST_GATE: assert property (!PORT_B_OPEN_DRAIN |-> !CLOCK_LINE_OE && !DATA_LINE_OE)
        else $error("pull while disabled");
    AST_DOE: assert property (dw && !PWDATA[0] |=> DATA_LINE_OE)
        else $error("data not pulled");
    AST_DREL: assert property (dw && PWDATA[0] |=> !DATA_LINE_OE)
        else $error("data not released");

    // Interrupt pulses and their cause
    AST_FPULSE: assert property (FALLING_COND_IRQ |=> !FALLING_COND_IRQ)
        else $error("fall irq too long");
    AST_RPULSE: assert property (RISING_COND_IRQ |=> !RISING_COND_IRQ)
        else $error("rise irq too long");
    AST_FCAUSE: assert property (FALLING_COND_IRQ |-> !$past(DATA_LINE_I, 2) && $past(CLOCK_LINE_I, 2))
        else $error("fall irq without cause");
    AST_RCAUSE: assert property (RISING_COND_IRQ |-> $past(DATA_LINE_I, 2) && $past(CLOCK_LINE_I, 2))
        else $error("rise irq without cause");

    cover property (FALLING_COND_IRQ);
    cover property (RISING_COND_IRQ);
    cover property (CLOCK_LINE_OE ##1 !CLOCK_LINE_OE);
endmodule

bind sla_sync_line_assist sla_assertions u_sla_chk (.MCLK, .NRST, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .CLOCK_LINE_I, .CLOCK_LINE_O, .CLOCK_LINE_OE, .DATA_LINE_I, .DATA_LINE_O,
    .DATA_LINE_OE, .PORT_B_OVERRIDE, .PORT_B_OPEN_DRAIN, .FALLING_COND_IRQ, .RISING_COND_IRQ);

// File: test/sla_line_partner.sv
module sla_line_partner
(
    input wire logic clk_oe,
    input wire logic dat_oe,
    input wire logic pull_clk,
    input wire logic pull_dat,
    output logic clk_wire,
    output logic dat_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wired-AND lines, pull-up when nobody pulls
    assign clk_wire = ~(clk_oe | pull_clk);
    assign dat_wire = ~(dat_oe | pull_dat);
endmodule

// File: test/sla_sync_line_assist_tb_top.sv
module sla_sync_line_assist_tb_top
    import sla_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic slv;
    logic pc = 1'b0;
    logic pd = 1'b0;
    logic clk_i;
    logic clk_oe;
    logic dat_i;
    logic dat_oe;
    logic fi;
    logic ri;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int nf = 0;
    int nr = 0;

    // 40 MHz system clock
    always #12.5 mclk = ~mclk;

    sla_sync_line_assist dut (.MCLK(mclk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CLOCK_LINE_I(clk_i), .CLOCK_LINE_O(), .CLOCK_LINE_OE(clk_oe),
        .DATA_LINE_I(dat_i), .DATA_LINE_O(), .DATA_LINE_OE(dat_oe), .PORT_B_OVERRIDE(),
        .PORT_B_OPEN_DRAIN(), .FALLING_COND_IRQ(fi), .RISING_COND_IRQ(ri));

    sla_line_partner peer (.clk_oe(clk_oe), .dat_oe(dat_oe), .pull_clk(pc), .pull_dat(pd),
        .clk_wire(clk_i), .dat_wire(dat_i));

    task automatic wrap_up;
        if (err_total == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Interrupt counting and hang guard
    always @(posedge mclk)
    begin
        cyc++;
        nf += int'(fi === 1'b1);
        nr += int'(ri === 1'b1);
        if (cyc == 5000)
        begin
            err_total++;
            wrap_up();
        end
    end

    function automatic logic [31:0] ctl(input int s, input int c, input int u, input int e);
        return {28'h0, s[0], c[0], u[0], e[0]};
    endfunction

    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One APB transfer, read data and error kept
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp(rd, e);
    endtask

    // Far side levels, one half of the 200 ns link period each
    task automatic pins(input logic c, input logic d);
        @(posedge mclk);
        pc <= !c;
        pd <= !d;
        hold(3);
    endtask

    // Clock low, data changed midway through the low half, then clock rises
    task automatic clock_bit(input logic b);
        @(posedge mclk);
        pc <= 1'b1;
        hold(1);
        @(posedge mclk);
        pd <= !b;
        hold(1);
        pins(1'b1, b);
    endtask

    initial
    begin
        logic b;
        b = 1'($urandom(32'hd582db91));
        hold(6);
        nrst <= 1'b1;
        chk(SLA_OFS_DATA_IO, 32'h1);
        chk(SLA_OFS_CLOCK_IO, 32'h1);
        chk(SLA_OFS_CONTROL, ctl(0, 0, 0, 0));
        chk(SLA_OFS_FALL_COND, 32'h0);
        chk(SLA_OFS_RISE_COND, 32'h0);
        chk(SLA_OFS_RISE_SEEN, 32'h0);
        chk(8'h1c, 32'h0);
        cmp({31'h0, slv}, 32'h1);
        // Conditions ignored while disabled
        pins(1'b1, 1'b0);
        pins(1'b1, 1'b1);
        chk(SLA_OFS_FALL_COND, 32'h0);
        chk(SLA_OFS_RISE_COND, 32'h0);
        cmp(32'(nf + nr), 32'h0);
        apb(1'b1, SLA_OFS_CONTROL, 32'hffff_fff1);
        chk(SLA_OFS_CONTROL, ctl(0, 0, 0, 1));
        // Own drive makes both conditions
        apb(1'b1, SLA_OFS_DATA_IO, 32'h0);
        hold(8);
        chk(SLA_OFS_DATA_IO, 32'h0);
        chk(SLA_OFS_FALL_COND, 32'h1);
        apb(1'b1, SLA_OFS_DATA_IO, 32'h1);
        hold(8);
        chk(SLA_OFS_RISE_COND, 32'h1);
        cmp(32'(nf * 16 + nr), 32'h11);
        apb(1'b1, SLA_OFS_FALL_COND, $urandom());
        apb(1'b1, SLA_OFS_RISE_COND, $urandom());
        chk(SLA_OFS_FALL_COND, 32'h0);
        chk(SLA_OFS_RISE_COND, 32'h0);
        // Far side pulls lines while drive bits are 1
        pins(1'b1, 1'b0);
        chk(SLA_OFS_DATA_IO, 32'h0);
        chk(SLA_OFS_FALL_COND, 32'h1);
        pins(1'b0, 1'b0);
        chk(SLA_OFS_CLOCK_IO, 32'h0);
        // Random bits sampled at clock rises
        repeat (16)
        begin
            b = 1'($urandom_range(1, 0));
            clock_bit(b);
            chk(SLA_OFS_RISE_SEEN, 32'h1);
            chk(SLA_OFS_SAMPLED, {31'h0, b});
            chk(SLA_OFS_RISE_SEEN, 32'h0);
        end
        // Unconditional stretch and release
        apb(1'b1, SLA_OFS_CONTROL, ctl(0, 0, 1, 1));
        clock_bit(1'b1);
        chk(SLA_OFS_CLOCK_IO, 32'h0);
        chk(SLA_OFS_CONTROL, ctl(1, 0, 1, 1));
        apb(1'b1, SLA_OFS_SAMPLED, $urandom());
        hold(8);
        chk(SLA_OFS_CLOCK_IO, 32'h1);
        chk(SLA_OFS_CONTROL, ctl(0, 0, 1, 1));
        // Conditional stretch only after a falling condition
        apb(1'b1, SLA_OFS_FALL_COND, 32'h0);
        apb(1'b1, SLA_OFS_CONTROL, ctl(0, 1, 0, 1));
        clock_bit(1'b1);
        chk(SLA_OFS_CLOCK_IO, 32'h1);
        pins(1'b1, 1'b0);
        hold(8);
        clock_bit(1'b0);
        chk(SLA_OFS_CONTROL, ctl(1, 1, 0, 1));
        apb(1'b1, SLA_OFS_SAMPLED, 32'h0);
        hold(8);
        chk(SLA_OFS_CLOCK_IO, 32'h1);
        // Mid-run reset clears flags, stretch and control, and sets drive bits back to 1
        pins(1'b1, 1'b1);
        chk(SLA_OFS_RISE_COND, 32'h1);
        apb(1'b1, SLA_OFS_CLOCK_IO, 32'h0);
        apb(1'b1, SLA_OFS_DATA_IO, 32'h0);
        hold(8);
        chk(SLA_OFS_CONTROL, ctl(1, 1, 0, 1));
        nrst <= 1'b0;
        hold(6);
        nrst <= 1'b1;
        chk(SLA_OFS_CONTROL, ctl(0, 0, 0, 0));
        chk(SLA_OFS_FALL_COND, 32'h0);
        chk(SLA_OFS_RISE_COND, 32'h0);
        chk(SLA_OFS_RISE_SEEN, 32'h0);
        apb(1'b1, SLA_OFS_CONTROL, ctl(0, 0, 0, 1));
        hold(8);
        chk(SLA_OFS_DATA_IO, 32'h1);
        chk(SLA_OFS_CLOCK_IO, 32'h1);
        wrap_up();
    end
endmodule
